// ===== verilog/mcsa_alu.sv
/*
 * sequencer of the magnitude and conditional-sum alu slice: decodes an
 * instruction, runs it over four clocks and presents result, flags and
 * write strobes.
 * assumes the core supplies the destination and source register values
 * with the start strobe, all on core_clk_i.
 */
`timescale 1ns/1ps
module mcsa_alu (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] dest_value_i,
	input  wire logic [31:0] src_value_i,
	input  wire logic        z_flag_i,
	input  wire logic        c_flag_i,
	output wire logic        ready_o,
	output wire logic        done_o,
	output wire logic [31:0] result_o,
	output wire logic [8:0]  dest_addr_o,
	output wire logic        z_o,
	output wire logic        c_o,
	output wire logic        wr_result_o,
	output wire logic        wr_z_o,
	output wire logic        wr_c_o,
	output wire logic        illegal_o
);
	mcsa_pkg::mcsa_state_t state_reg;
	mcsa_pkg::mcsa_state_t state_next;
	logic [5:0]  op_reg;
	logic [3:0]  eff_reg;
	logic [3:0]  cond_reg;
	logic [8:0]  dest_reg;
	logic [31:0] d_reg;
	logic [31:0] s_reg;
	logic        c_reg;
	logic        z_reg;
	logic [31:0] result_reg;
	logic        zo_reg;
	logic        co_reg;
	logic        wr_r_reg;
	logic        wr_z_reg;
	logic        wr_c_reg;
	logic        illegal_reg;

	wire logic        accept_w;
	wire logic [31:0] src_sel_w;
	wire logic        exec_w;
	wire logic        finish_w;

	mcsa_calc_if calc_bus ();

	mcsa_calc mcsa_calc_i (
		.bus (calc_bus.calc)
	);

	////////////////////////////////////////////////////////////////////
	// decode: immediate source is the zero-extended source field
	assign accept_w  = start_i && ready_o;
	assign src_sel_w = instr_i[mcsa_pkg::EFF_I] ?
		{23'h0, instr_i[mcsa_pkg::SRC_MSB:mcsa_pkg::SRC_LSB]} :
		src_value_i;
	// execute when the condition bit picked by {c,z} is set
	assign exec_w   = cond_reg[{c_reg, z_reg}];
	assign finish_w = (state_reg == mcsa_pkg::ST_CALC);

	// operands to the arithmetic unit
	assign calc_bus.op   = op_reg;
	assign calc_bus.d    = d_reg;
	assign calc_bus.s    = s_reg;
	assign calc_bus.c_in = c_reg;
	assign calc_bus.z_in = z_reg;

	////////////////////////////////////////////////////////////////////
	// four-clock sequence; a new start may be taken in the done cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			mcsa_pkg::ST_IDLE: begin
				if (start_i) begin
					state_next = mcsa_pkg::ST_DECODE;
				end
			end
			mcsa_pkg::ST_DECODE: begin
				state_next = mcsa_pkg::ST_OPER;
			end
			mcsa_pkg::ST_OPER: begin
				state_next = mcsa_pkg::ST_CALC;
			end
			mcsa_pkg::ST_CALC: begin
				state_next = mcsa_pkg::ST_DONE;
			end
			mcsa_pkg::ST_DONE: begin
				state_next = start_i ? mcsa_pkg::ST_DECODE :
					mcsa_pkg::ST_IDLE;
			end
			default: begin
				state_next = mcsa_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= mcsa_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// capture the instruction fields and operands on accept
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_reg   <= mcsa_pkg::OPC_RST;
			eff_reg  <= mcsa_pkg::NIBBLE_RST;
			cond_reg <= mcsa_pkg::NIBBLE_RST;
			dest_reg <= mcsa_pkg::DEST_RST;
			d_reg    <= mcsa_pkg::RESULT_RST;
			s_reg    <= mcsa_pkg::RESULT_RST;
			c_reg    <= 1'b0;
			z_reg    <= 1'b0;
		end else if (accept_w) begin
			op_reg   <= instr_i[mcsa_pkg::OPC_MSB:mcsa_pkg::OPC_LSB];
			eff_reg  <= instr_i[mcsa_pkg::EFF_Z:mcsa_pkg::EFF_I];
			cond_reg <= instr_i[mcsa_pkg::COND_MSB:mcsa_pkg::COND_LSB];
			dest_reg <= instr_i[mcsa_pkg::DST_MSB:mcsa_pkg::DST_LSB];
			d_reg    <= dest_value_i;
			s_reg    <= src_sel_w;
			c_reg    <= c_flag_i;
			z_reg    <= z_flag_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// result and flags are loaded as the calc cycle ends
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_reg  <= mcsa_pkg::RESULT_RST;
			zo_reg      <= 1'b0;
			co_reg      <= 1'b0;
			illegal_reg <= 1'b0;
		end else if (finish_w) begin
			result_reg  <= calc_bus.result;
			zo_reg      <= calc_bus.zero;
			co_reg      <= calc_bus.carry;
			illegal_reg <= ~calc_bus.valid;
		end
	end

	// write strobes: one-cycle pulses in done, gated by effect bits
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_r_reg <= 1'b0;
			wr_z_reg <= 1'b0;
			wr_c_reg <= 1'b0;
		end else begin
			wr_z_reg <= finish_w && exec_w && calc_bus.valid && eff_reg[3];
			wr_c_reg <= finish_w && exec_w && calc_bus.valid && eff_reg[2];
			wr_r_reg <= finish_w && exec_w && calc_bus.valid && eff_reg[1];
		end
	end

	assign ready_o     = (state_reg == mcsa_pkg::ST_IDLE) ||
		(state_reg == mcsa_pkg::ST_DONE);
	assign done_o      = (state_reg == mcsa_pkg::ST_DONE);
	assign result_o    = result_reg;
	assign dest_addr_o = dest_reg;
	assign z_o         = zo_reg;
	assign c_o         = co_reg;
	assign wr_result_o = wr_r_reg;
	assign wr_z_o      = wr_z_reg;
	assign wr_c_o      = wr_c_reg;
	assign illegal_o   = illegal_reg;

	////////////////////////////////////////////////////////////////////
	// checking helpers: expected values worked out from the inputs
	wire logic [5:0]  chk_opc_w;
	wire logic [31:0] chk_mag_w;
	wire logic [32:0] chk_addabs_w;
	wire logic [32:0] chk_subtract_magnitude_op_w;
	wire logic [31:0] chk_plus_w;
	wire logic [31:0] chk_minus_w;
	wire logic        chk_neg_w;
	wire logic [31:0] chk_sum_w;
	wire logic        chk_ovf_w;

	assign chk_opc_w    = instr_i[mcsa_pkg::OPC_MSB:mcsa_pkg::OPC_LSB];
	assign chk_mag_w    = src_sel_w[31] ? (32'h0 - src_sel_w) : src_sel_w;
	assign chk_addabs_w = {1'b0, dest_value_i} + {1'b0, chk_mag_w};
	assign chk_subtract_magnitude_op_w = {1'b0, dest_value_i} - {1'b0, chk_mag_w};
	assign chk_plus_w   = dest_value_i + src_sel_w;
	assign chk_minus_w  = dest_value_i - src_sel_w;
	assign chk_neg_w    = chk_opc_w[1] ? (z_flag_i ^ chk_opc_w[0]) :
		(c_flag_i ^ chk_opc_w[0]);
	assign chk_sum_w    = chk_neg_w ? chk_minus_w : chk_plus_w;
	assign chk_ovf_w    = chk_neg_w ?
		((dest_value_i[31] ^ src_sel_w[31]) &
		(chk_sum_w[31] ^ dest_value_i[31])) :
		(~(dest_value_i[31] ^ src_sel_w[31]) &
		(chk_sum_w[31] ^ dest_value_i[31]));

	property p_decode_timing;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		accept_w |-> ##4 (done_o && dest_addr_o ==
			$past(instr_i[mcsa_pkg::DST_MSB:mcsa_pkg::DST_LSB], 4));
	endproperty
	a_decode_timing: assert property (p_decode_timing) else
		$error("done or destination wrong four clocks after start");

	property p_single_done;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		done_o |=> !done_o;
	endproperty
	a_single_done: assert property (p_single_done) else
		$error("done held longer than one cycle");

	property p_addabs;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::ADD_MAGNITUDE_OP) |-> ##4
		(result_o == $past(chk_addabs_w[31:0], 4) &&
		c_o == $past(chk_addabs_w[32], 4));
	endproperty
	a_addabs: assert property (p_addabs) else
		$error("magnitude add result or carry wrong");

	property p_subtract_magnitude_op;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::SUBTRACT_MAGNITUDE_OP) |-> ##4
		(result_o == $past(chk_subtract_magnitude_op_w[31:0], 4) &&
		c_o == $past(chk_subtract_magnitude_op_w[32], 4));
	endproperty
	a_subtract_magnitude_op: assert property (p_subtract_magnitude_op) else
		$error("magnitude subtract result or borrow wrong");

	property p_sum_carry;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::SUM_NEGATED_ON_CARRY_OP) |->
		##4 (result_o == $past(chk_sum_w, 4) && c_o == $past(chk_ovf_w, 4));
	endproperty
	a_sum_carry: assert property (p_sum_carry) else
		$error("sum negated on carry wrong");

	property p_sum_no_carry;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::SUM_NEGATED_ON_NO_CARRY_OP) |->
		##4 (result_o == $past(chk_sum_w, 4) && c_o == $past(chk_ovf_w, 4));
	endproperty
	a_sum_no_carry: assert property (p_sum_no_carry) else
		$error("sum negated on no carry wrong");

	property p_sum_null;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::SUM_NEGATED_ON_RESULT_NULL_OP)
		|-> ##4 (result_o == $past(chk_sum_w, 4) &&
		c_o == $past(chk_ovf_w, 4));
	endproperty
	a_sum_null: assert property (p_sum_null) else
		$error("sum negated on zero flag wrong");

	property p_sum_nonnull;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(accept_w && chk_opc_w == mcsa_pkg::SUM_NEGATED_ON_NONNULL_OP) |->
		##4 (result_o == $past(chk_sum_w, 4) && c_o == $past(chk_ovf_w, 4));
	endproperty
	a_sum_nonnull: assert property (p_sum_nonnull) else
		$error("sum negated on clear zero flag wrong");

	property p_zero_flag;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(done_o && !illegal_o) |-> (z_o == (result_o == 32'h0));
	endproperty
	a_zero_flag: assert property (p_zero_flag) else
		$error("zero flag does not match result");

	property p_cov_addabs;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		accept_w && chk_opc_w == mcsa_pkg::ADD_MAGNITUDE_OP ##4 wr_result_o;
	endproperty
	c_addabs: cover property (p_cov_addabs);

	property p_cov_negated;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		accept_w && chk_neg_w && chk_opc_w[5:2] == 4'h9 ##4 c_o;
	endproperty
	c_negated: cover property (p_cov_negated);

	property p_cov_back_to_back;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		done_o && accept_w;
	endproperty
	c_back_to_back: cover property (p_cov_back_to_back);

	property p_cov_illegal;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		done_o && illegal_o;
	endproperty
	c_illegal: cover property (p_cov_illegal);
endmodule

// ===== verilog/mcsa_pkg.sv
/*
 * constants for the magnitude and conditional-sum alu slice: field
 * positions of the instruction word, operation codes, fsm states and
 * reset values.
 * assumes a single core clock and an active-low asynchronous reset.
 */
// Functional notes
// - add source magnitude, unsigned carry, four clocks
// - subtract source magnitude, unsigned borrow, four clocks
// - carry set subtracts else adds, signed overflow
// - carry set adds else subtracts, signed overflow
// - zero set subtracts else adds, signed overflow
// - zero set adds else subtracts, signed overflow
package mcsa_pkg;

	////////////////////////////////////////////////////////////////////
	// instruction word layout
	localparam int OPC_MSB  = 31;
	localparam int OPC_LSB  = 26;
	localparam int EFF_Z    = 25;
	localparam int EFF_C    = 24;
	localparam int EFF_R    = 23;
	localparam int EFF_I    = 22;
	localparam int COND_MSB = 21;
	localparam int COND_LSB = 18;
	localparam int DST_MSB  = 17;
	localparam int DST_LSB  = 9;
	localparam int SRC_MSB  = 8;
	localparam int SRC_LSB  = 0;

	////////////////////////////////////////////////////////////////////
	// operation codes handled by this slice
	localparam logic [5:0] ADD_MAGNITUDE_OP              = 6'h22;
	localparam logic [5:0] SUBTRACT_MAGNITUDE_OP         = 6'h23;
	localparam logic [5:0] SUM_NEGATED_ON_CARRY_OP       = 6'h24;
	localparam logic [5:0] SUM_NEGATED_ON_NO_CARRY_OP    = 6'h25;
	localparam logic [5:0] SUM_NEGATED_ON_RESULT_NULL_OP = 6'h26;
	localparam logic [5:0] SUM_NEGATED_ON_NONNULL_OP     = 6'h27;

	////////////////////////////////////////////////////////////////////
	// timing and reset values
	localparam int          EXEC_CLOCKS = 4;
	localparam logic [31:0] RESULT_RST  = 32'h0;
	localparam logic [8:0]  DEST_RST    = 9'h0;
	localparam logic [5:0]  OPC_RST     = 6'h0;
	localparam logic [3:0]  NIBBLE_RST  = 4'h0;

	// gray coded along idle, decode, operand, calc, done
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_DECODE = 3'h1,
		ST_OPER   = 3'h3,
		ST_CALC   = 3'h2,
		ST_DONE   = 3'h6
	} mcsa_state_t;

endpackage

// ===== verilog/mcsa_calc_if.sv
/*
 * bundle between the sequencer and the arithmetic unit.
 * assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface mcsa_calc_if;
	logic [5:0]  op;
	logic [31:0] d;
	logic [31:0] s;
	logic        c_in;
	logic        z_in;
	logic [31:0] result;
	logic        carry;
	logic        zero;
	logic        valid;

	modport calc (
		input  op, d, s, c_in, z_in,
		output result, carry, zero, valid
	);
	modport user (
		output op, d, s, c_in, z_in,
		input  result, carry, zero, valid
	);
endinterface

// ===== verilog/mcsa_calc.sv
/*
 * combinational arithmetic unit: magnitude add/subtract and the four
 * conditional-sign sums, with zero, carry/borrow and overflow.
 * assumes operands are stable registers of the sequencer.
 */
`timescale 1ns/1ps
module mcsa_calc (
	mcsa_calc_if.calc bus
);
	wire logic        is_abs_w;
	wire logic        neg_w;
	wire logic [31:0] mag_w;
	wire logic [31:0] opnd_w;
	wire logic [32:0] plus_w;
	wire logic [32:0] minus_w;
	wire logic [32:0] res_w;
	wire logic        ovf_w;

	////////////////////////////////////////////////////////////////////
	// operand select: magnitude for the abs ops, raw source otherwise
	assign is_abs_w = (bus.op == mcsa_pkg::ADD_MAGNITUDE_OP) ||
		(bus.op == mcsa_pkg::SUBTRACT_MAGNITUDE_OP);
	assign mag_w  = bus.s[31] ? (~bus.s + 32'h1) : bus.s;
	assign opnd_w = is_abs_w ? mag_w : bus.s;

	// direction: fixed for the magnitude ops, else the flag decides whether the source is negated
	assign neg_w =
		(bus.op == mcsa_pkg::SUBTRACT_MAGNITUDE_OP)         ? 1'b1 :
		(bus.op == mcsa_pkg::SUM_NEGATED_ON_CARRY_OP)       ? bus.c_in :
		(bus.op == mcsa_pkg::SUM_NEGATED_ON_NO_CARRY_OP)    ? ~bus.c_in :
		(bus.op == mcsa_pkg::SUM_NEGATED_ON_RESULT_NULL_OP) ? bus.z_in :
		(bus.op == mcsa_pkg::SUM_NEGATED_ON_NONNULL_OP)     ? ~bus.z_in :
		1'b0;

	////////////////////////////////////////////////////////////////////
	// 33-bit sum and difference; bit 32 is carry or borrow
	assign plus_w  = {1'b0, bus.d} + {1'b0, opnd_w};
	assign minus_w = {1'b0, bus.d} - {1'b0, opnd_w};
	assign res_w   = neg_w ? minus_w : plus_w;

	// signed overflow for the conditional sums
	assign ovf_w = neg_w ?
		((bus.d[31] != opnd_w[31]) && (res_w[31] != bus.d[31])) :
		((bus.d[31] == opnd_w[31]) && (res_w[31] != bus.d[31]));

	assign bus.result = res_w[31:0];
	assign bus.zero   = (res_w[31:0] == 32'h0);
	assign bus.carry  = is_abs_w ? res_w[32] : ovf_w;
	assign bus.valid  = is_abs_w || (bus.op[5:2] == 4'h9);
endmodule

// ===== verif/mcsa_alu_test.sv
/*
 * self-checking bench for the magnitude and conditional-sum alu slice:
 * every opcode, flag-driven sign choice, effect bits, condition field,
 * immediate source, unknown opcode, refused start and mid-run reset.
 * assumes a 40 MHz core clock and the fixed four-clock handshake.
 */
`timescale 1ns/1ps
module mcsa_alu_test;
	logic        core_clk_i;
	logic        rst_n_i;
	logic        start_i;
	logic [31:0] instr_i;
	logic [31:0] dest_value_i;
	logic [31:0] src_value_i;
	logic        z_flag_i;
	logic        c_flag_i;
	wire logic        ready_o;
	wire logic        done_o;
	wire logic [31:0] result_o;
	wire logic [8:0]  dest_addr_o;
	wire logic        z_o;
	wire logic        c_o;
	wire logic        wr_result_o;
	wire logic        wr_z_o;
	wire logic        wr_c_o;
	wire logic        illegal_o;
	int          bad_count;
	int          tests_run;

	mcsa_alu mcsa_alu_i (
		.core_clk_i   (core_clk_i),
		.rst_n_i      (rst_n_i),
		.start_i      (start_i),
		.instr_i      (instr_i),
		.dest_value_i (dest_value_i),
		.src_value_i  (src_value_i),
		.z_flag_i     (z_flag_i),
		.c_flag_i     (c_flag_i),
		.ready_o      (ready_o),
		.done_o       (done_o),
		.result_o     (result_o),
		.dest_addr_o  (dest_addr_o),
		.z_o          (z_o),
		.c_o          (c_o),
		.wr_result_o  (wr_result_o),
		.wr_z_o       (wr_z_o),
		.wr_c_o       (wr_c_o),
		.illegal_o    (illegal_o)
	);

	////////////////////////////////////////////////////////////////////
	// clock, 25 ns period
	always #12.5 core_clk_i = ~core_clk_i;

	// compare and count
	task automatic chk(input logic [31:0] seen, exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// reference: {carry, result} worked out from the operation
	function automatic logic [32:0] model(input logic [5:0] op,
		input logic [31:0] d, s, input logic z, c);
		logic [32:0] a;
		logic [32:0] r;
		logic        neg;
		a = s[31] ? {1'b0, -s} : {1'b0, s};
		neg = (op == 6'h24) ? c : (op == 6'h25) ? !c :
			(op == 6'h26) ? z : !z;
		if (op == mcsa_pkg::ADD_MAGNITUDE_OP) return {1'b0, d} + a;
		if (op == mcsa_pkg::SUBTRACT_MAGNITUDE_OP) return {1'b0, d} - a;
		r[31:0] = neg ? d - s : d + s;
		r[32] = (neg ? d[31] != s[31] : d[31] == s[31]) &&
			r[31] != d[31];
		return r;
	endfunction

	function automatic logic [31:0] mk(input logic [5:0] op,
		input logic [3:0] eff, cnd, input logic [8:0] dst, src);
		return {op, eff, cnd, dst, src};
	endfunction

	// one instruction; waits for an edge, then drives the request
	task automatic run_op(input logic [31:0] ins, d, s,
		input logic z, c, poke);
		logic [32:0] e;
		logic        ex;
		logic        lg;
		e = model(ins[31:26], d, ins[22] ? {23'h0, ins[8:0]} : s, z, c);
		ex = ins[mcsa_pkg::COND_LSB + {c, z}];
		lg = (ins[31:26] >= 6'h22) && (ins[31:26] <= 6'h27);
		@(posedge core_clk_i);
		instr_i <= ins;
		dest_value_i <= d;
		src_value_i <= s;
		z_flag_i <= z;
		c_flag_i <= c;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= poke;
		dest_value_i <= d ^ 32'h5; // a start while busy must be ignored
		@(posedge core_clk_i);
		start_i <= 1'b0;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(done_o, 1'b0, "done early");
		chk(ready_o, 1'b0, "ready busy");
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(done_o, 1'b1, "done");
		chk(ready_o, 1'b1, "ready done");
		chk(illegal_o, !lg, "illegal");
		chk(dest_addr_o, ins[17:9], "dest");
		chk(wr_result_o, ins[23] & ex & lg, "wr res");
		chk(wr_z_o, ins[25] & ex & lg, "wr z");
		chk(wr_c_o, ins[24] & ex & lg, "wr c");
		if (lg) begin
			chk(result_o, e[31:0], "result");
			chk(z_o, e[31:0] == 32'h0, "zero");
			chk(c_o, e[32], "carry");
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// every opcode, both flag states, boundary and overflow values
	localparam logic [3:0] EF = 4'he;
	localparam logic [3:0] AL = 4'hf;
	task automatic t_ops;
		run_op(mk(6'h22, EF, AL, 9'h3, 9'h0), 5, -3, 0, 0, 0);
		run_op(mk(6'h22, EF, AL, 9'h4, 9'h0), -1, 1, 0, 0, 0);
		run_op(mk(6'h22, EF, AL, 9'h5, 9'h0), 1, 32'h80000000,
			0, 0, 1);
		run_op(mk(6'h23, EF, AL, 9'h6, 9'h0), 3, -3, 0, 0, 0);
		run_op(mk(6'h23, EF, AL, 9'h7, 9'h0), 2, 5, 0, 0, 0);
		run_op(mk(6'h24, EF, AL, 9'h8, 9'h0), 32'h80000000, 1,
			0, 1, 0);
		run_op(mk(6'h24, EF, AL, 9'h9, 9'h0), 7, 2, 0, 0, 0);
		run_op(mk(6'h25, EF, AL, 9'ha, 9'h0), 32'h7fffffff, 1,
			0, 1, 0);
		run_op(mk(6'h25, EF, AL, 9'hb, 9'h0), 4, 4, 0, 0, 0);
		run_op(mk(6'h26, EF, AL, 9'hc, 9'h0), 4, 4, 1, 0, 0);
		run_op(mk(6'h26, EF, AL, 9'hd, 9'h0), 1, 2, 0, 0, 0);
		run_op(mk(6'h27, EF, AL, 9'he, 9'h0), 1, 2, 1, 0, 0);
		run_op(mk(6'h27, EF, AL, 9'h1ff, 9'h0), 1, 2, 0, 1, 0);
	endtask

	// effect bits, immediate source, condition field, unknown opcodes
	task automatic t_fields;
		run_op(mk(6'h22, 4'h9, 4'hf, 9'h11, 9'h1ff), 1, -7,
			0, 0, 0);
		run_op(mk(6'h23, 4'he, 4'h0, 9'h12, 9'h0), 9, 2, 1, 1, 0);
		run_op(mk(6'h24, 4'h4, 4'h2, 9'h13, 9'h0), 9, 2, 1, 0, 0);
		run_op(mk(6'h25, 4'ha, 4'h2, 9'h14, 9'h0), 9, 2, 0, 1, 0);
		run_op(mk(6'h21, 4'he, 4'hf, 9'h15, 9'h0), 9, 2, 0, 0, 0);
		run_op(mk(6'h28, 4'he, 4'hf, 9'h16, 9'h0), 9, 2, 0, 0, 0);
		@(negedge core_clk_i);
		chk(done_o, 1'b0, "done pulse");
		chk(wr_result_o, 1'b0, "wr pulse");
	endtask

	// reset in the middle of an instruction clears the outputs
	task automatic t_reset;
		run_op(mk(6'h22, 4'he, 4'hf, 9'h17, 9'h0), 6, 1, 0, 0, 0);
		@(posedge core_clk_i);
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		@(negedge core_clk_i);
		chk(ready_o, 1'b1, "rst ready");
		chk(done_o, 1'b0, "rst done");
		chk(result_o, 32'h0, "rst result");
		chk(dest_addr_o, 9'h0, "rst dest");
		chk(wr_result_o, 1'b0, "rst wr");
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		run_op(mk(6'h23, 4'he, 4'hf, 9'h18, 9'h0), 6, 1, 0, 0, 0);
	endtask

	// a start in the done cycle is taken at once
	task automatic t_b2b;
		@(posedge core_clk_i);
		instr_i <= mk(6'h24, 4'he, 4'hf, 9'h19, 9'h0);
		dest_value_i <= 32'h10;
		src_value_i <= 32'h3;
		z_flag_i <= 1'b0;
		c_flag_i <= 1'b0;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		instr_i <= mk(6'h23, 4'he, 4'hf, 9'h1a, 9'h0);
		src_value_i <= 32'hfffffffc;
		start_i <= 1'b1;
		@(negedge core_clk_i);
		chk(done_o, 1'b1, "b2b done");
		chk(result_o, 32'h13, "b2b first");
		@(posedge core_clk_i);
		start_i <= 1'b0;
		@(negedge core_clk_i);
		chk(ready_o, 1'b0, "b2b taken");
		chk(dest_addr_o, 9'h1a, "b2b dest");
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(done_o, 1'b1, "b2b done 2");
		chk(result_o, 32'hc, "b2b second");
		chk(c_o, 1'b0, "b2b borrow");
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		core_clk_i = 1'b0;
		rst_n_i = 1'b0;
		start_i = 1'b0;
		instr_i = 32'h0;
		dest_value_i = 32'h0;
		src_value_i = 32'h0;
		z_flag_i = 1'b0;
		c_flag_i = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		chk(ready_o, 1'b1, "reset ready");
		chk(illegal_o, 1'b0, "reset illegal");
		t_ops();
		t_fields();
		t_reset();
		t_b2b();
		report_and_stop();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk_i);
		bad_count++;
		report_and_stop();
	end
endmodule
